/* rolling_shutter_scan_sequencer_tb_top.sv */
// self-checking bench for the scan sequencer
`timescale 1ns/1ps
`default_nettype none
module rolling_shutter_scan_sequencer_tb_top;
    import rss_pkg::*;
    typedef struct packed {
        logic        vf;
        logic [1:0]  w;
        logic [10:0] n;
        logic [10:0] sel;
        logic        eos_n;
    } rss_row_t;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [4:0]  avs_address = 5'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        yr_ck, yr_st, yl_ck, yl_st, x_ck, x_st, adc_ck;
    logic [15:0] sample_level = 16'h0000;
    logic [10:0] readout_row_sel, reset_row_sel, column_sel, s;
    logic [2:0]  end_of_scan_flag_n;
    logic [9:0]  pixel_code;
    logic [3:0]  gain_code, offset_code;
    logic        fast_calib, unity_feedback, busy;
    logic        go = 1'b0;
    logic [1:0]  which = 2'h0;
    logic [10:0] n_fall = 11'h000;
    logic [31:0] q;
    int          n_mismatch = 0;
    int          comparisons = 0;
    logic [15:0] lv [5] = '{REF_LOW, REF_LOW + 16'h3ff0, 16'hffff,
                            REF_LOW + 16'h0640, REF_LOW + 16'h0640};
    logic        gm [5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
    logic [9:0]  ex [5] = '{10'h000, 10'h3ff, 10'h3ff, 10'h064, 10'h000};
    rss_row_t    rows [14] = '{
        '{1'b0, 2'h0, 11'h001, 11'h000, 1'b1},
        '{1'b0, 2'h0, 11'h002, 11'h001, 1'b1},
        '{1'b0, 2'h1, 11'h407, 11'h406, 1'b1},
        '{1'b0, 2'h0, 11'h408, 11'h000, 1'b0},
        '{1'b0, 2'h0, 11'h409, 11'h000, 1'b1},
        '{1'b0, 2'h2, 11'h002, 11'h000, 1'b1},
        '{1'b0, 2'h2, 11'h508, 11'h506, 1'b1},
        '{1'b0, 2'h2, 11'h509, 11'h000, 1'b0},
        '{1'b1, 2'h0, 11'h003, 11'h005, 1'b1},
        '{1'b1, 2'h1, 11'h103, 11'h405, 1'b1},
        '{1'b1, 2'h0, 11'h104, 11'h000, 1'b0},
        '{1'b1, 2'h2, 11'h003, 11'h001, 1'b1},
        '{1'b1, 2'h2, 11'h143, 11'h501, 1'b1},
        '{1'b1, 2'h2, 11'h144, 11'h000, 1'b0}};

    rss_sequencer uut (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .readout_row_clock(yr_ck),
        .readout_row_start_n(yr_st), .reset_row_clock(yl_ck),
        .reset_row_start_n(yl_st), .column_clock(x_ck),
        .column_start_n(x_st), .converter_clock(adc_ck),
        .sample_level(sample_level), .readout_row_sel(readout_row_sel),
        .reset_row_sel(reset_row_sel), .column_sel(column_sel),
        .end_of_scan_flag_n(end_of_scan_flag_n), .pixel_code(pixel_code),
        .gain_code(gain_code), .offset_code(offset_code),
        .fast_calib(fast_calib), .unity_feedback(unity_feedback));
    rss_ctrl_model ctrl (.clk(clk), .go(go), .which(which), .n_fall(n_fall),
        .busy(busy), .readout_row_clock(yr_ck), .readout_row_start_n(yr_st),
        .reset_row_clock(yl_ck), .reset_row_start_n(yl_st),
        .column_clock(x_ck), .column_start_n(x_st), .converter_clock(adc_ck));

    // 50 ns period
    always #25 clk = ~clk;

    task automatic check(input string nm, input logic [31:0] e,
                         input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            n_mismatch++;
        end
    endtask

    // request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [4:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        // waitrequest and read data are taken at the rising edge itself
        do
        begin
            @(posedge clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 20);
        if (avs_waitrequest !== 1'b0)
            n_mismatch++;
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    // one start pulse then n falling edges on the chosen register
    task automatic scan(input logic [1:0] w, input logic [10:0] n);
        int t;
        t = 0;
        @(posedge clk);
        which <= w;
        n_fall <= n;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        @(negedge clk);
        while (busy !== 1'b0 && t < 20000)
        begin
            t++;
            @(negedge clk);
        end
        if (t == 20000)
            n_mismatch++;
        repeat (4) @(negedge clk);
    endtask

    function automatic logic [9:0] gam(input int x);
        real y;
        y = 1024.0 * (1.0 - $exp(-x / 713.0)) / (1.0 - $exp(-1024.0 / 713.0));
        return 10'($rtoi(y + 0.5));
    endfunction

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // main sequence
    initial
    begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(negedge clk);
        check("eos idle", 32'h7, 32'(end_of_scan_flag_n));
        check("pixel idle", 32'h0, 32'(pixel_code));
        bus(1'b1, ADDR_ROWS, 32'hffffffff);
        bus(1'b0, ADDR_ROWS, 32'h0);
        check("rows read only", 32'h0, q);
        bus(1'b0, 5'h14, 32'h0);
        check("unmapped", 32'h0, q);
        bus(1'b0, ADDR_CTRL, 32'h0);
        check("ctrl untouched", 32'h0, q);
        $display("test reset done");
        foreach (rows[k])
        begin
            bus(1'b1, ADDR_CTRL, {30'h0, rows[k].vf, 1'b0});
            scan(rows[k].w, rows[k].n);
            s = (rows[k].w == 2'h0) ? readout_row_sel :
                (rows[k].w == 2'h1) ? reset_row_sel : column_sel;
            check("sel", 32'(rows[k].sel), 32'(s));
            check("eos", 32'(rows[k].eos_n),
                  32'(end_of_scan_flag_n[rows[k].w]));
            $display("test row %0d done", k);
        end
        bus(1'b0, ADDR_COL, 32'h0);
        check("col status", (32'h2 << COL_EOS_LSB) | 32'h144, q);
        bus(1'b0, ADDR_ROWS, 32'h0);
        check("rows status", (32'h103 << ROWS_RST_LSB) | 32'h104,
              q);
        ex[4] = gam(100);
        foreach (lv[k])
        begin
            bus(1'b1, ADDR_CTRL, {31'h0, gm[k]});
            sample_level <= lv[k];
            scan(2'h2, 11'h002);
            check("pixel", 32'(ex[k]), 32'(pixel_code));
            bus(1'b0, ADDR_PIXEL, 32'h0);
            check("pixel reg", 32'(ex[k]), q);
        end
        // inverse law on the gamma code of linear 100 gives about twice it
        check("inverse law", 32'h0c8,
              32'($rtoi(-1426.0 * $ln(1.0 - q / 1343.5) + 0.5)));
        bus(1'b1, ADDR_CTRL, 32'h0);
        sample_level <= REF_LOW + 16'h0100;
        scan(2'h2, 11'h001);
        sample_level <= REF_LOW + 16'h0200;
        scan(2'h2, 11'h001);
        check("pixel lag", 32'h10, 32'(pixel_code));
        $display("test converter done");
        bus(1'b1, ADDR_CTRL, 32'h568);
        repeat (2) @(negedge clk);
        check("config", 32'h296, 32'({gain_code, offset_code, fast_calib,
              unity_feedback}));
        bus(1'b0, ADDR_CTRL, 32'h0);
        check("ctrl", 32'h568, q);
        bus(1'b1, ADDR_CTRL, 32'h800);
        repeat (2) @(negedge clk);
        check("unity", 32'h1, 32'({gain_code, offset_code, fast_calib,
              unity_feedback}));
        $display("test config done");
        scan(2'h1, 11'h000);
        scan(2'h0, 11'h005);
        scan(2'h0, 11'h000);
        bus(1'b0, ADDR_INTEG, 32'h0);
        check("integration", 32'h5, q);
        $display("test integration done");
        // reset in mid-run must clear the control word and the pixel
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(negedge clk);
        check("pixel reset", 32'h0, 32'(pixel_code));
        check("unity reset", 32'h0, 32'(unity_feedback));
        bus(1'b0, ADDR_CTRL, 32'h0);
        check("ctrl reset", 32'h0, q);
        $display("test second reset done");
        conclude();
    end

    // watchdog well beyond the expected run length
    initial
    begin
        repeat (90000) @(posedge clk);
        n_mismatch++;
        conclude();
    end
endmodule // rolling_shutter_scan_sequencer_tb_top
`default_nettype wire

/* rss_ctrl_model.sv */
// timing controller model: shift clocks and start pulses
`timescale 1ns/1ps
`default_nettype none
module rss_ctrl_model (
    input  wire logic        clk,                 // system clock
    input  wire logic        go,                  // begin one scan
    input  wire logic [1:0]  which,               // 0 yr, 1 yl, 2 column
    input  wire logic [10:0] n_fall,              // falling edges to give
    output logic             busy,                // scan in progress
    output logic             readout_row_clock,   // readout row clock
    output logic             readout_row_start_n, // readout start, low
    output logic             reset_row_clock,     // reset row clock
    output logic             reset_row_start_n,   // reset start, low
    output logic             column_clock,        // column clock
    output logic             column_start_n,      // column start, low
    output logic             converter_clock      // follows column clock
);
    logic [2:0] ck = 3'h7;
    logic [2:0] st = 3'h7;
    int         i;
    logic       busy_reg = 1'b0;  // one process owns the busy flag
    // clocks rest high between scans, so a start is always legal
    always
    begin
        @(posedge clk);
        if (go)
        begin
            busy_reg <= 1'b1;
            st[which] <= 1'b0;
            repeat (4) @(posedge clk);
            st[which] <= 1'b1;
            repeat (4) @(posedge clk);
            // three cycles per level, the design's sync minimum
            for (i = 0; i < n_fall; i++)
            begin
                ck[which] <= 1'b0;
                repeat (3) @(posedge clk);
                ck[which] <= 1'b1;
                repeat (3) @(posedge clk);
            end
            busy_reg <= 1'b0;
        end
    end
    assign busy = busy_reg;
    // one clock drives column and converter
    assign readout_row_clock   = ck[0];
    assign reset_row_clock     = ck[1];
    assign column_clock        = ck[2];
    assign converter_clock     = ck[2];
    assign readout_row_start_n = st[0];
    assign reset_row_start_n   = st[1];
    assign column_start_n      = st[2];
endmodule // rss_ctrl_model
`default_nettype wire

/* rss_pkg.sv */
// shared constants and types for the rolling shutter scan sequencer
package rss_pkg;
    // register byte offsets on the avalon slave
    localparam logic [4:0]  ADDR_CTRL  = 5'h00;
    localparam logic [4:0]  ADDR_ROWS  = 5'h04;
    localparam logic [4:0]  ADDR_COL   = 5'h08;
    localparam logic [4:0]  ADDR_INTEG = 5'h0c;
    localparam logic [4:0]  ADDR_PIXEL = 5'h10;
    // field positions in the status words
    localparam int          ROWS_RST_LSB = 16;
    localparam int          COL_EOS_LSB  = 16;
    localparam logic [11:0] CTRL_RESET   = 12'h000;
    // scan positions: clocks after the start pulse
    localparam logic [10:0] POS_FIRST    = 11'h002;
    localparam logic [10:0] FULL_ROW_EOS = 11'h408;  // 1032
    localparam logic [10:0] FULL_COL_EOS = 11'h509;  // 1289
    localparam logic [10:0] VF_ROW_EOS   = 11'h104;  // 260
    localparam logic [10:0] VF_COL_EOS   = 11'h144;  // 324
    // converter: input steps above the low reference per code
    localparam logic [15:0] REF_LOW      = 16'h2000;
    localparam int          STEP_SHIFT   = 4;
    localparam logic [9:0]  CODE_MAX     = 10'h3ff;  // 1023
    localparam real         GAMMA_K      = 713.0;
    localparam real         GAMMA_FULL   = 1024.0;

    // per frame configuration, software writable
    typedef struct packed {
        logic       unity_feedback;
        logic       fast_calib;
        logic [3:0] offset_code;
        logic [3:0] gain_code;
        logic       viewfinder_select;
        logic       gamma_select;
    } rss_cfg_t;

    // linear level to 10-bit code, clamped at both references
    function automatic logic [9:0] rss_linear(input logic [15:0] level);
        logic [15:0] d;
        d = level - REF_LOW;
        if (level <= REF_LOW)
            return 10'h000;
        else if ((d >> STEP_SHIFT) > 16'(CODE_MAX))
            return CODE_MAX;
        else
            return d[STEP_SHIFT +: 10];
    endfunction

    // non-linear law, evaluated only at elaboration to fill a table
    function automatic logic [9:0] rss_gamma(input int x);
        real y;
        y = GAMMA_FULL * (1.0 - $exp(-x / GAMMA_K))
            / (1.0 - $exp(-GAMMA_FULL / GAMMA_K));
        if (y >= 1023.0)
            return CODE_MAX;
        else
            return 10'($rtoi(y + 0.5));
    endfunction
endpackage

/* rss_sequencer.sv */
// scan shift registers, converter coding and avalon registers
`timescale 1ns/1ps
`default_nettype none
module rss_sequencer
    import rss_pkg::*;
(
    input  wire logic        clk,                   // 20 MHz system clock
    input  wire logic        rst_n,                 // sync reset, low
    input  wire logic [4:0]  avs_address,           // byte address
    input  wire logic        avs_read,              // read request
    input  wire logic        avs_write,             // write request
    input  wire logic [31:0] avs_writedata,         // write data
    output logic      [31:0] avs_readdata,          // read data
    output logic             avs_waitrequest,       // stall request
    input  wire logic        readout_row_clock,     // readout row shift clk
    input  wire logic        readout_row_start_n,   // readout start, low
    input  wire logic        reset_row_clock,       // reset row shift clk
    input  wire logic        reset_row_start_n,     // reset start, low
    input  wire logic        column_clock,          // column shift clock
    input  wire logic        column_start_n,        // column start, low
    input  wire logic        converter_clock,       // converter clock
    input  wire logic [15:0] sample_level,          // converter input level
    output logic      [10:0] readout_row_sel,       // row read, 0 = none
    output logic      [10:0] reset_row_sel,         // row reset, 0 = none
    output logic      [10:0] column_sel,            // column, 0 = dark
    output logic      [2:0]  end_of_scan_flag_n,    // yr, yl, x; low
    output logic      [9:0]  pixel_code,            // converted pixel
    output logic      [3:0]  gain_code,             // amplifier gain
    output logic      [3:0]  offset_code,           // amplifier offset
    output logic             fast_calib,            // fast offset calib
    output logic             unity_feedback         // amp unity feedback
);
    logic [1:0][3:0]  clk_sync_reg;   // stage 0 feeds only stage 1
    logic [3:0]       clk_prev_reg;
    logic [1:0][2:0]  start_sync_reg;
    logic [1:0][15:0] level_sync_reg;
    logic [3:0]       fall;
    logic [2:0]       start;
    logic [2:0][10:0] pos_reg;
    logic [2:0][10:0] end_of_scan_flag;
    logic [2:0][10:0] pos_next;
    logic [2:0][10:0] sel_next;
    logic [10:0]      integ_cnt_reg;
    logic [10:0]      integ_reg;
    logic [9:0]       held_reg;
    logic [9:0]       lut [1024];
    rss_cfg_t         cfg_reg;
    logic             hit;
    logic [31:0]      rd_mux;

    // pin inputs pass two flops; multi-bit level is only read at a
    // converter edge, by which time it has long settled
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            clk_sync_reg   <= '0;
            clk_prev_reg   <= '0;
            start_sync_reg <= '1;
            level_sync_reg <= '0;
        end
        else
        begin
            clk_sync_reg[0]   <= {converter_clock, column_clock,
                                  reset_row_clock, readout_row_clock};
            clk_sync_reg[1]   <= clk_sync_reg[0];
            clk_prev_reg      <= clk_sync_reg[1];
            start_sync_reg[0] <= {column_start_n, reset_row_start_n,
                                  readout_row_start_n};
            start_sync_reg[1] <= start_sync_reg[0];
            level_sync_reg[0] <= sample_level;
            level_sync_reg[1] <= level_sync_reg[0];
        end
    end

    assign fall  = clk_prev_reg & ~clk_sync_reg[1];
    assign start = ~start_sync_reg[1];

    // scan step: start clears, each falling edge advances to one past end-of-scan
    // and then parks there so the dark level stays out
    always_comb
    begin
        for (int c = 0; c < 3; c++)
        begin
            if (c == 2)
                end_of_scan_flag[c] = cfg_reg.viewfinder_select ? VF_COL_EOS
                                                   : FULL_COL_EOS;
            else
                end_of_scan_flag[c] = cfg_reg.viewfinder_select ? VF_ROW_EOS
                                                   : FULL_ROW_EOS;
            pos_next[c] = pos_reg[c];
            if (start[c])
                pos_next[c] = '0;
            else if (fall[c] && pos_reg[c] <= end_of_scan_flag[c])
                pos_next[c] = pos_reg[c] + 11'h001;
            sel_next[c] = '0;
            if (pos_next[c] >= POS_FIRST && pos_next[c] < end_of_scan_flag[c])
            begin
                if (cfg_reg.viewfinder_select && c == 2)
                    sel_next[c] = (pos_next[c] == POS_FIRST) ? 11'h000 :
                        11'({pos_next[c] - 11'h003, 2'b00} + 13'h0001);
                else if (cfg_reg.viewfinder_select)
                    sel_next[c] =
                        11'({pos_next[c] - POS_FIRST, 2'b00} + 13'h0001);
                else if (c == 2)
                    sel_next[c] = pos_next[c] - 11'h002;
                else
                    sel_next[c] = pos_next[c] - 11'h001;
            end
        end
    end

    // scan positions and registered selections
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            pos_reg            <= '0;
            readout_row_sel    <= '0;
            reset_row_sel      <= '0;
            column_sel         <= '0;
            end_of_scan_flag_n <= '1;
        end
        else
        begin
            pos_reg         <= pos_next;
            readout_row_sel <= sel_next[0];
            reset_row_sel   <= sel_next[1];
            column_sel      <= sel_next[2];
            for (int c = 0; c < 3; c++)
                end_of_scan_flag_n[c] <= (pos_next[c] != end_of_scan_flag[c]);
        end
    end

    // integration in whole readout rows from reset start to readout start
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            integ_cnt_reg <= '0;
            integ_reg     <= '0;
        end
        else
        begin
            if (start[1])
                integ_cnt_reg <= '0;
            else if (fall[0])
                integ_cnt_reg <= integ_cnt_reg + 11'h001;
            if (start[0] && !start_sync_reg[1][0] == 1'b1
                && clk_prev_reg[0])
                integ_reg <= integ_cnt_reg;
        end
    end

    // gamma table built from the exponential law at elaboration
    for (genvar i = 0; i < 1024; i++)
    begin : g_lut
        assign lut[i] = rss_gamma(i);
    end

    // converter samples on the falling edge; output shows the previous
    // pixel, so the code lags the analog selection by one pixel
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            held_reg   <= '0;
            pixel_code <= '0;
        end
        else if (fall[3])
        begin
            held_reg <= cfg_reg.gamma_select
                ? lut[rss_linear(level_sync_reg[1])]
                : rss_linear(level_sync_reg[1]);
            pixel_code <= held_reg;
        end
    end

    // avalon slave: one wait cycle, then the access completes
    assign hit = (avs_read || avs_write) && avs_waitrequest;
    always_comb
    begin
        case (avs_address)
            ADDR_CTRL:  rd_mux = {20'h00000, cfg_reg};
            ADDR_ROWS:  rd_mux = {5'h00, pos_reg[1], 5'h00, pos_reg[0]};
            ADDR_COL:   rd_mux = {13'h0000, end_of_scan_flag_n,
                                  5'h00, pos_reg[2]};
            ADDR_INTEG: rd_mux = {21'h000000, integ_reg};
            ADDR_PIXEL: rd_mux = {22'h000000, pixel_code};
            default:    rd_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= '0;
            cfg_reg         <= rss_cfg_t'(CTRL_RESET);
        end
        else
        begin
            avs_waitrequest <= !hit;
            if (hit)
                avs_readdata <= rd_mux;
            if (avs_write && !avs_waitrequest && avs_address == ADDR_CTRL)
                cfg_reg <= rss_cfg_t'(avs_writedata[11:0]);
        end
    end

    // amplifier codes and calibration straight from the control word
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            gain_code      <= '0;
            offset_code    <= '0;
            fast_calib     <= 1'b0;
            unity_feedback <= 1'b0;
        end
        else
        begin
            gain_code      <= cfg_reg.gain_code;
            offset_code    <= cfg_reg.offset_code;
            fast_calib     <= cfg_reg.fast_calib;
            unity_feedback <= cfg_reg.unity_feedback;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_start_clears: assert property (start[0] |=> pos_reg[0] == 0)
        else $error("start did not clear readout row position");
    a_row_advance: assert property (
        !start[0] && fall[0] && pos_reg[0] < end_of_scan_flag[0]
        |=> pos_reg[0] == $past(pos_reg[0]) + 11'h001)
        else $error("readout row did not advance on falling edge");
    a_row_hold: assert property (
        !start[1] && !fall[1] |=> $stable(pos_reg[1]))
        else $error("reset row moved without a falling edge");
    a_eos_after_last: assert property (
        !start[2] && fall[2] && pos_reg[2] == end_of_scan_flag[2] - 11'h001
        && $stable(cfg_reg) |=> !end_of_scan_flag_n[2])
        else $error("column end-of-scan missing after last pixel");
    a_full_first_row: assert property (
        !cfg_reg.viewfinder_select && pos_reg[0] == 11'h002
        && $stable(cfg_reg) |-> readout_row_sel == 11'h001)
        else $error("full mode row 1 not at clock 2");
    a_vf_col_dark: assert property (
        cfg_reg.viewfinder_select && pos_reg[2] == 11'h002
        && $stable(cfg_reg) |-> column_sel == 11'h000)
        else $error("viewfinder column not dark at clock 2");
    a_pixel_lag: assert property (
        fall[3] |=> pixel_code == $past(held_reg))
        else $error("pixel code not one pixel behind");
    a_code_low: assert property (
        fall[3] && level_sync_reg[1] <= REF_LOW |=> held_reg == 10'h000)
        else $error("low reference did not give code 0");
    a_bus_answer: assert property (
        (avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("waitrequest did not drop for exactly one cycle");

    c_row_eos: cover property (!end_of_scan_flag_n[0]);
    c_vf_col_eos: cover property (
        cfg_reg.viewfinder_select && !end_of_scan_flag_n[2]);
    c_gamma_pixel: cover property (cfg_reg.gamma_select && fall[3]);
endmodule // rss_sequencer
`default_nettype wire
